//--- logic/sst_timer.sv
// Functional notes
// - Watchdog is 16-bit down counter from reload.
// - Watchdog mode resets to 0x00020000, longest count.
// - Watchdog steps once per 128 slow clocks.
// - Overflow sets watchdog flag, may interrupt.
// - Overflow resets device only if enabled.
// - After overflow watchdog reloads and keeps counting.
// - Watchdog mode write never restarts countdown.
// - Control write reloads watchdog and clears prescaler.
// - Watchdog reload zero means 65536 steps.
// - Seconds counter: 20 bits, programmable prescaler.
// - Seconds prescaler resets to 0x8000.
// - Seconds counter wraps silently after 1048576.
// - Seconds equal alarm sets alarm flag.
// - Alarm resets to zero, the longest delay.
// - Every seconds increment sets tick flag.
// - Seconds mode write restarts prescaler, clears count.
// - Seconds prescaler zero means 65536 periods.
// - Period reload 16 bits, zero means 65536.
// - Period counter zero sets flag, reloads; write restarts.
// - Status flags sticky, cleared by status read.
// - Enable sets mask bits, disable clears them.
`timescale 1ns/1ps
`include "sst_timer_consts.svh"

module sst_timer
   import sst_timer_pkg::*;
(
   input  wire logic        clk_sys_i,
   input  wire logic        rst_i,
   input  wire logic        slow_clock_i,
   input  wire logic [5:0]  addr_i,
   input  wire logic [31:0] wr_data_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic [31:0]      rd_data_o,
   output logic             irq_o,
   output logic             wdt_reset_o
);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Counters run from load-1 down to zero, so a programmed zero wraps
   // to 16'hFFFF and yields the full 65536-cycle span.
   function automatic logic [15:0] sst_load(input logic [15:0] v);
      sst_load = v - 16'h0001;
   endfunction

   function automatic logic sst_hit(input sst_bus_req_t r, input logic [5:0] ofs);
      sst_hit = r.wr && (r.addr == ofs);
   endfunction

   sst_state_t   q;
   sst_state_t   d;
   sst_bus_req_t req;
   logic         slow_tick;
   logic         wdt_step;
   logic         sec_step;
   logic [3:0]   events;

   assign req.addr    = addr_i;
   assign req.wr_data = wr_data_i;
   assign req.wr      = wr_i;
   assign req.rd      = rd_i;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      d         = q;
      events    = 4'h0;
      wdt_step  = 1'b0;
      sec_step  = 1'b0;
      d.wdt_reset = 1'b0;

      // The slow clock is a pin; a level change is accepted only once the
      // last two stages agree, so a metastable first stage never reaches logic.
      d.slow_sync = {q.slow_sync[1:0], slow_clock_i};
      if (q.slow_sync[1] == q.slow_sync[2])
      begin
         d.slow_lvl = q.slow_sync[2];
      end
      slow_tick = d.slow_lvl && !q.slow_lvl;

      // Periodic interval unit.
      if (slow_tick)
      begin
         if (q.period_cnt == 16'h0000)
         begin
            events[`SST_FLG_PERIOD] = 1'b1;
            d.period_cnt = sst_load(q.period_reload_value);
         end
         else
         begin
            d.period_cnt = q.period_cnt - 16'h0001;
         end
      end

      // Watchdog unit.
      if (slow_tick)
      begin
         d.wdt_div = q.wdt_div + 7'h01;
         wdt_step  = (q.wdt_div == `SST_WDT_DIV_LAST);
      end
      if (wdt_step)
      begin
         if (q.wdt_cnt == 16'h0000)
         begin
            events[`SST_FLG_WATCHDOG_OVERFLOW_FLAG] = 1'b1;
            d.wdt_reset = q.wdmr[`SST_BIT_OVERFLOW_RESET_ENABLE];
            d.wdt_cnt   = sst_load(q.wdmr[15:0]);
         end
         else
         begin
            d.wdt_cnt = q.wdt_cnt - 16'h0001;
         end
      end

      // Seconds counter unit.
      if (slow_tick)
      begin
         if (q.sec_div == 16'h0000)
         begin
            sec_step  = 1'b1;
            d.sec_div = sst_load(q.seconds_prescaler_value);
         end
         else
         begin
            d.sec_div = q.sec_div - 16'h0001;
         end
      end
      if (sec_step)
      begin
         d.seconds = q.seconds + 20'h00001;
         events[`SST_FLG_TICK] = 1'b1;
         // Alarm of zero matches only on the wrap, the longest delay.
         if (d.seconds == q.alarm_value)
         begin
            events[`SST_FLG_ALARM] = 1'b1;
         end
      end

      // Register writes take priority over a coinciding count step.
      if (sst_hit(req, `SST_OFS_CTRL))
      begin
         // Any write restarts, whatever the kick bit holds.
         d.wdt_cnt = sst_load(q.wdmr[15:0]);
         d.wdt_div = 7'h00;
      end
      if (sst_hit(req, `SST_OFS_PIMR))
      begin
         d.period_reload_value = req.wr_data[15:0];
         d.period_cnt = sst_load(req.wr_data[15:0]);
      end
      if (sst_hit(req, `SST_OFS_WDMR))
      begin
         d.wdmr = req.wr_data[17:0];
      end
      if (sst_hit(req, `SST_OFS_RTMR))
      begin
         d.seconds_prescaler_value = req.wr_data[15:0];
         d.sec_div = sst_load(req.wr_data[15:0]);
         d.seconds = 20'h00000;
         events[`SST_FLG_TICK]  = 1'b0;
         events[`SST_FLG_ALARM] = 1'b0;
      end
      if (sst_hit(req, `SST_OFS_ALARM))
      begin
         d.alarm_value = req.wr_data[19:0];
      end
      if (sst_hit(req, `SST_OFS_IEN))
      begin
         d.mask = q.mask | req.wr_data[3:0];
      end
      if (sst_hit(req, `SST_OFS_IDIS))
      begin
         d.mask = q.mask & ~req.wr_data[3:0];
      end

      // Sticky flags: a new event beats the read that clears.
      if (req.rd && (req.addr == `SST_OFS_STATUS))
      begin
         d.flags = events;
      end
      else
      begin
         d.flags = q.flags | events;
      end

      // Read data stands only in the cycle after the strobe.
      d.rd_data = 32'h0000_0000;
      if (req.rd)
      begin
         unique case (req.addr)
            `SST_OFS_PIMR:    d.rd_data = {16'h0000, q.period_reload_value};
            `SST_OFS_WDMR:    d.rd_data = {14'h0000, q.wdmr};
            `SST_OFS_RTMR:    d.rd_data = {16'h0000, q.seconds_prescaler_value};
            `SST_OFS_STATUS:  d.rd_data = {28'h0000000, q.flags};
            `SST_OFS_IMASK:   d.rd_data = {28'h0000000, q.mask};
            `SST_OFS_ALARM:   d.rd_data = {12'h000, q.alarm_value};
            `SST_OFS_CURRENT: d.rd_data = {12'h000, q.seconds};
            default:          d.rd_data = 32'h0000_0000;
         endcase
      end

      d.irq = |(d.flags & d.mask);
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         q <= '0;
         q.period_reload_value     <= `SST_RST_PIMR;
         q.period_cnt              <= 16'hFFFF;
         q.wdmr                    <= `SST_RST_WDMR;
         q.wdt_cnt                 <= 16'hFFFF;
         q.seconds_prescaler_value <= `SST_RST_RTMR;
         q.sec_div                 <= 16'h7FFF;
         q.alarm_value             <= `SST_RST_ALARM;
         q.mask                    <= `SST_RST_MASK;
      end
      else
      begin
         q <= d;
      end
   end

   assign rd_data_o   = q.rd_data;
   assign irq_o       = q.irq;
   assign wdt_reset_o = q.wdt_reset;

endmodule

//--- logic/sst_timer_consts.svh
`ifndef SST_TIMER_CONSTS_SVH
`define SST_TIMER_CONSTS_SVH

// Register byte offsets.
`define SST_OFS_CTRL       6'h00
`define SST_OFS_PIMR       6'h04
`define SST_OFS_WDMR       6'h08
`define SST_OFS_RTMR       6'h0C
`define SST_OFS_STATUS     6'h10
`define SST_OFS_IEN        6'h14
`define SST_OFS_IDIS       6'h18
`define SST_OFS_IMASK      6'h1C
`define SST_OFS_ALARM      6'h20
`define SST_OFS_CURRENT    6'h24

// Field positions.
`define SST_BIT_KICK       0
`define SST_BIT_OVERFLOW_RESET_ENABLE      16
`define SST_FLG_PERIOD     0
`define SST_FLG_WATCHDOG_OVERFLOW_FLAG      1
`define SST_FLG_TICK       2
`define SST_FLG_ALARM      3

// Reset values.
`define SST_RST_PIMR       16'h0000
`define SST_RST_WDMR       18'h20000
`define SST_RST_RTMR       16'h8000
`define SST_RST_ALARM      20'h00000
`define SST_RST_MASK       4'h0

// Watchdog prescaler: slow clock cycles per watchdog step, less one.
`define SST_WDT_DIV_LAST   7'h7F

`endif

//--- logic/sst_timer_pkg.sv
package sst_timer_pkg;

   typedef struct packed {
      logic [2:0]  slow_sync;
      logic        slow_lvl;
      logic [15:0] period_cnt;
      logic [6:0]  wdt_div;
      logic [15:0] wdt_cnt;
      logic [15:0] sec_div;
      logic [19:0] seconds;
      logic [15:0] period_reload_value;
      logic [17:0] wdmr;
      logic [15:0] seconds_prescaler_value;
      logic [19:0] alarm_value;
      logic [3:0]  flags;
      logic [3:0]  mask;
      logic [31:0] rd_data;
      logic        irq;
      logic        wdt_reset;
   } sst_state_t;

   typedef struct packed {
      logic [5:0]  addr;
      logic [31:0] wr_data;
      logic        wr;
      logic        rd;
   } sst_bus_req_t;

endpackage

//--- verification/sst_timer_props.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Port relations of the system timer.
// ---------------------------------------------------------------
module sst_timer_props (
   input wire logic        clk_sys_i,
   input wire logic        rst_i,
   input wire logic        slow_clock_i,
   input wire logic [5:0]  addr_i,
   input wire logic [31:0] wr_data_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [31:0] rd_data_o,
   input wire logic        irq_o,
   input wire logic        wdt_reset_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   AST_RD_IDLE: assert property (!rd_i |=> rd_data_o == 32'h0)
      else $error("read data not zero outside a read");
   AST_WO_RD: assert property (rd_i && (addr_i == 6'h00 || addr_i == 6'h14 || addr_i == 6'h18)
      |=> rd_data_o == 32'h0) else $error("write-only register read back nonzero");
   AST_RD_16: assert property (rd_i && (addr_i == 6'h04 || addr_i == 6'h0C)
      |=> rd_data_o[31:16] == 16'h0) else $error("reload field wider than 16 bits");
   AST_WDMR_RD: assert property (rd_i && addr_i == 6'h08 |=> rd_data_o[31:18] == 14'h0)
      else $error("watchdog mode upper bits set");
   AST_SEC_RD: assert property (rd_i && addr_i == 6'h24 |=> rd_data_o[31:20] == 12'h0)
      else $error("seconds value wider than 20 bits");
   AST_ST_RD: assert property (rd_i && (addr_i == 6'h10 || addr_i == 6'h1C)
      |=> rd_data_o[31:4] == 28'h0) else $error("status or mask upper bits set");
   AST_RST_PULSE: assert property (wdt_reset_o |=> !wdt_reset_o [*8])
      else $error("internal reset longer than one cycle");
   AST_IRQ_OFF: assert property (wr_i && addr_i == 6'h18 && wr_data_i[3:0] == 4'hF
      ##1 !(wr_i && addr_i == 6'h14) [*2] |=> !irq_o) else $error("interrupt with all masks clear");
   AST_ALARM_RB: assert property (wr_i && addr_i == 6'h20 ##1 rd_i && addr_i == 6'h20
      |=> rd_data_o[19:0] == $past(wr_data_i[19:0], 2)) else $error("alarm readback differs");
   AST_SEC_CLR: assert property (wr_i && addr_i == 6'h0C ##1 rd_i && addr_i == 6'h24
      |=> rd_data_o == 32'h0) else $error("seconds not cleared by mode write");
endmodule

//--- verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic        clk_sys_i    = 1'b0;
   logic        rst_i        = 1'b1;
   logic        slow_clock_i = 1'b0;
   logic [5:0]  addr_i       = 6'h00;
   logic [31:0] wr_data_i    = 32'h0;
   logic        wr_i         = 1'b0;
   logic        rd_i         = 1'b0;
   logic [31:0] rd_data_o;
   logic        irq_o;
   logic        wdt_reset_o;
   int          fail_count   = 0;
   int          compares     = 0;
   int          seed         = 55;
   int          rst_cnt      = 0;
   int          n;
   logic [31:0] v;
   logic [5:0]  ra [11] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h1C, 6'h20, 6'h24, 6'h28};
   logic [31:0] rv [11] = '{32'h0, 32'h0, 32'h00020000, 32'h00008000, 32'h0, 32'h0, 32'h0, 32'h0,
                            32'h0, 32'h0, 32'h0};

   always #20 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) if (wdt_reset_o === 1'b1) rst_cnt <= rst_cnt + 1;

   sst_timer DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .slow_clock_i(slow_clock_i), .addr_i(addr_i),
      .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .irq_o(irq_o),
      .wdt_reset_o(wdt_reset_o));

   // ---------------------------------------------------------------
   // Bus and slow clock tasks; each is entered just after an edge.
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      wr_i      <= 1'b1;
      addr_i    <= a;
      wr_data_i <= d;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
   endtask
   task automatic rdc(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
      rd_i   <= 1'b1;
      addr_i <= a;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      #1 chk(rd_data_o & m, e);
      @(posedge clk_sys_i);
   endtask
   // Ten bus cycles per slow period keeps clear of the synchroniser limit.
   task automatic slow(input int k);
      repeat (k)
      begin
         slow_clock_i <= 1'b1;
         repeat (5) @(posedge clk_sys_i);
         slow_clock_i <= 1'b0;
         repeat (5) @(posedge clk_sys_i);
      end
   endtask
   task automatic print_verdict;
      if (fail_count == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial
   begin
      #(40 * 30000);
      fail_count++;
      print_verdict();
   end

   initial
   begin
      repeat (2) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      @(posedge clk_sys_i);
      foreach (ra[i]) rdc(ra[i], 32'hFFFFFFFF, rv[i]);
      repeat (3)
      begin
         v = $random(seed);
         wr(6'h20, v);
         rdc(6'h20, 32'hFFFFFFFF, {12'h0, v[19:0]});
      end
      n = 1 + ($random(seed) & 3);
      wr(6'h04, 32'(n));
      wr(6'h14, 32'h1);
      rdc(6'h1C, 32'hFFFFFFFF, 32'h1);
      slow(n - 1);
      rdc(6'h10, 32'h1, 32'h0);
      slow(1);
      chk({31'h0, irq_o}, 32'h1);
      rdc(6'h10, 32'h1, 32'h1);
      rdc(6'h10, 32'hF, 32'h0);
      chk({31'h0, irq_o}, 32'h0);
      wr(6'h18, 32'hF);
      rdc(6'h1C, 32'hFFFFFFFF, 32'h0);
      slow(n);
      chk({31'h0, irq_o}, 32'h0);
      wr(6'h0C, 32'h2);
      slow(4);
      rdc(6'h24, 32'hFFFFFFFF, 32'h2);
      wr(6'h0C, 32'h2);
      rdc(6'h24, 32'hFFFFFFFF, 32'h0);
      wr(6'h20, 32'h3);
      rdc(6'h10, 32'h0, 32'h0);
      slow(5);
      rdc(6'h10, 32'hC, 32'h4);
      slow(1);
      rdc(6'h24, 32'hFFFFFFFF, 32'h3);
      rdc(6'h24, 32'hFFFFFFFF, 32'h3);
      rdc(6'h10, 32'hC, 32'hC);
      wr(6'h08, 32'h00010002);
      wr(6'h00, 32'h1);
      slow(200);
      wr(6'h00, 32'h1);
      slow(100);
      wr(6'h08, 32'h00000003);
      rdc(6'h10, 32'h0, 32'h0);
      slow(155);
      rdc(6'h10, 32'h2, 32'h0);
      slow(1);
      rdc(6'h10, 32'h2, 32'h2);
      chk(rst_cnt, 32'h0);
      wr(6'h08, 32'h00010002);
      wr(6'h00, 32'h1);
      slow(256);
      rdc(6'h10, 32'h2, 32'h2);
      chk(rst_cnt, 32'h1);
      slow(256);
      rdc(6'h10, 32'h2, 32'h2);
      print_verdict();
   end
endmodule

bind sst_timer sst_timer_props PROPS (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .slow_clock_i(slow_clock_i),
   .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
   .irq_o(irq_o), .wdt_reset_o(wdt_reset_o));
